// [design/hdt_pkg.sv]
// hdt_pkg: constants and carriers for the hypervisor debug trap control block
// assumes one 125 MHz core clock; shared by all design files
package hdt_pkg;

    localparam int HDT_XLEN = 32;

    // register field positions
    localparam int HDT_BIT_ROM_TRAP   = 11;
    localparam int HDT_BIT_OS_TRAP    = 10;
    localparam int HDT_BIT_DBG_TRAP   = 9;
    localparam int HDT_BIT_DBG_ROUTE  = 8;
    localparam int HDT_BIT_HYP_CNT_EN = 7;
    localparam int HDT_BIT_MON_TRAP   = 6;
    localparam int HDT_BIT_MCR_TRAP   = 5;
    localparam int HDT_SPLIT_MSB      = 4;
    localparam int HDT_SPLIT_W        = 5;

    // coprocessor move encoding of this register
    localparam logic [2:0] HDT_OPC1   = 3'h4;
    localparam logic [2:0] HDT_OPC2   = 3'h1;
    localparam logic [3:0] HDT_CRN    = 4'h1;
    localparam logic [3:0] HDT_CRM    = 4'h1;
    localparam logic [3:0] HDT_CP_SYS = 4'hf;
    localparam logic [3:0] HDT_CP_DBG = 4'he;

    // reset values
    localparam logic HDT_RST_TRAP   = 1'b0;
    // counter enable resets to an unknown value; zero is a legal choice
    localparam logic HDT_RST_CNT_EN = 1'b0;

    typedef enum logic [1:0] {
        HDT_EL0,
        HDT_EL1,
        HDT_EL2
    } hdt_el_t;

    // class of register touched by a lower-level system access
    typedef enum logic [2:0] {
        HDT_R_NONE,
        HDT_R_DEBUG,
        HDT_R_DBG_XFER,
        HDT_R_DBG_ROM,
        HDT_R_DBG_PWR,
        HDT_R_PMU,
        HDT_R_PMU_CTRL
    } hdt_rclass_t;

    typedef struct packed {
        logic        valid;
        hdt_el_t     el;
        hdt_rclass_t rclass;
        logic        external;
    } hdt_acc_t;

    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic [2:0]           opc1;
        logic [2:0]           opc2;
        logic [3:0]           crn;
        logic [3:0]           crm;
        logic [3:0]           coproc;
        hdt_el_t              el;
        logic [HDT_XLEN-1:0]  wdata;
    } hdt_mcr_t;

    typedef enum logic [1:0] {
        HDT_ST_IDLE,
        HDT_ST_DONE,
        HDT_ST_TRAP
    } hdt_state_t;

endpackage

// [design/hdt_trap_decode.sv]
// hdt_trap_decode: combinational trap decision for one lower-level access
// assumes effective control bits already include the override terms
`timescale 1ns/1ps
module hdt_trap_decode
    import hdt_pkg::*;
(
    input  wire hdt_acc_t acc,
    input  wire logic     debug_halt,
    input  wire logic     rom_eff,
    input  wire logic     os_eff,
    input  wire logic     dbg_eff,
    input  wire logic     route_eff,
    input  wire logic     mon_trap,
    input  wire logic     mcr_trap,
    output logic          trap
);
    logic lower;
    logic is_dbg;

    always_comb
    begin
        lower  = acc.valid && (acc.el != HDT_EL2);
        // powerdown registers are undefined at the lowest level, not trapped
        is_dbg = (acc.rclass == HDT_R_DEBUG) || (acc.rclass == HDT_R_DBG_XFER)
              || (acc.rclass == HDT_R_DBG_ROM)
              || (acc.rclass == HDT_R_DBG_PWR && acc.el == HDT_EL1);
        trap = 1'b0;
        if (lower)
        begin
            case (acc.rclass)
                HDT_R_DBG_ROM:  trap = rom_eff;
                HDT_R_DBG_PWR:  trap = os_eff && (acc.el == HDT_EL1);
                HDT_R_DEBUG:    trap = dbg_eff;
                HDT_R_DBG_XFER: trap = dbg_eff && !debug_halt;
                HDT_R_PMU:      trap = mon_trap && !acc.external;
                HDT_R_PMU_CTRL: trap = (mon_trap || mcr_trap) && !acc.external;
                default:        trap = 1'b0;
            endcase
            // routing bit traps every debug access that is otherwise legal, except transfer accesses in debug halt
            if (is_dbg && route_eff && !(acc.rclass == HDT_R_DBG_XFER && debug_halt))
            begin
                trap = 1'b1;
            end
        end
    end
endmodule

// [design/hdt_counter_split.sv]
// hdt_counter_split: per-counter ownership and enable from the split field
// assumes counter index space of CNT_MAX counters
`timescale 1ns/1ps
module hdt_counter_split
    import hdt_pkg::*;
#(
    parameter int CNT_MAX = 31
)
(
    input  wire logic [HDT_SPLIT_W-1:0] split,
    input  wire logic [HDT_SPLIT_W-1:0] impl_count,
    input  wire logic                   global_en,
    input  wire logic                   hyp_cnt_en,
    input  wire logic                   hyp_disable,
    input  wire logic                   in_hyp,
    output logic [CNT_MAX-1:0]          lower_owned,
    output logic [CNT_MAX-1:0]          counter_run
);
    logic [HDT_SPLIT_W-1:0] eff_split;

    // illegal split reserves all counters for the hypervisor
    always_comb
    begin
        if (split == '0 || split > impl_count)
            eff_split = '0;
        else
            eff_split = split;
    end

    genvar g;
    generate
        for (g = 0; g < CNT_MAX; g++)
        begin : g_cnt
            localparam logic [HDT_SPLIT_W-1:0] IDX = HDT_SPLIT_W'(g);
            wire implemented = IDX < impl_count;
            wire low         = IDX < eff_split;
            assign lower_owned[g] = implemented && low;
            assign counter_run[g] = implemented && (low
                ? (global_en && !(hyp_disable && in_hyp))
                : hyp_cnt_en);
        end
    endgenerate
endmodule

// [design/hdt_ctrl.sv]
// hdt_ctrl: hypervisor debug trap control register and trap routing
// Notes on behaviour
// - debug-access trap sends lower-level 1110-space debug accesses to hypervisor
// - in debug halt, transfer receive/transmit register accesses are never trapped
// - general trap or routing bit forces debug-access trap; reads show stored bit
// - routing bit sends lower-level debug exceptions to the hypervisor level
// - routing bit traps every debug register access that is otherwise defined, except transfer accesses in debug halt
// - general trap enable acts as routing bit, except for direct reads
// - hypervisor counter enable runs the hypervisor-reserved counters
// - monitor-access trap traps lower-level performance monitor accesses
// - external debug interface accesses bypass performance monitor traps
// - monitor-control trap traps lower-level control register accesses
// - without performance monitors, counter fields read zero and ignore writes
// - split field holds count of lower-level accessible counters
// - counters below split follow global enable, stopped in hypervisor by disable
// - counters from split upward are hypervisor-only and follow counter enable
// - zero or oversize split reserves all counters to the hypervisor
// - reset loads the implemented counter count into the split field
// - reset clears trap and routing bits; counter enable takes zero
// - register is read and written by coprocessor move 4,c1,c1,1 on cp 1111
// - group-1 trap bit traps first-level accesses to this register
// - ROM-address trap sends lower-level ROM address register accesses up
// - OS-related trap sends first-level powerdown register accesses up
// assumes the core presents one move request at a time and holds until answered
`timescale 1ns/1ps
module hdt_ctrl
    import hdt_pkg::*;
#(
    parameter bit PMU_PRESENT = 1'b1,
    parameter int CNT_MAX     = 31,
    parameter logic [HDT_SPLIT_W-1:0] IMPL_COUNT = 5'h06
)
(
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire hdt_mcr_t            mcr,
    input  wire hdt_acc_t            acc,
    input  wire logic                general_trap_enable,
    input  wire logic                group1_register_trap,
    input  wire logic                debug_halt,
    input  wire logic                dbg_exc_req,
    input  wire hdt_el_t             dbg_exc_el,
    input  wire logic                global_counter_enable,
    input  wire logic                hyp_counting_disable,
    input  wire logic                rom_address_trap,
    input  wire logic                os_related_trap,
    input  wire logic                in_hyp,
    output logic                     mcr_done,
    output logic                     mcr_trap_exc,
    output logic [HDT_XLEN-1:0]      mcr_rdata,
    output logic                     acc_trap,
    output logic                     dbg_exc_to_hyp,
    output logic [CNT_MAX-1:0]       lower_owned,
    output logic [CNT_MAX-1:0]       counter_run,
    output logic [HDT_XLEN-1:0]      hyp_debug_trap_control
);
    logic                   debug_access_trap_q;
    logic                   debug_exception_route_q;
    logic                   hyp_counter_enable_q;
    logic                   monitor_access_trap_q;
    logic                   monitor_control_trap_q;
    logic [HDT_SPLIT_W-1:0] counter_split_q;
    hdt_state_t             state_q;
    logic                   hit;
    logic                   take_trap;
    logic                   route_eff;
    logic                   dbg_eff;
    logic                   rom_eff;
    logic                   os_eff;
    logic                   acc_trap_c;
    logic [HDT_XLEN-1:0]    reg_view;
    logic [CNT_MAX-1:0]     lower_owned_c;
    logic [CNT_MAX-1:0]     counter_run_c;

    function automatic logic is_this_reg(input hdt_mcr_t m);
        return m.coproc == HDT_CP_SYS && m.opc1 == HDT_OPC1 && m.opc2 == HDT_OPC2
            && m.crn == HDT_CRN && m.crm == HDT_CRM;
    endfunction

    assign hit       = mcr.valid && is_this_reg(mcr) && (state_q == HDT_ST_IDLE);
    // lowest level has no access; first level only under the group trap
    assign take_trap = (mcr.el == HDT_EL0)
                    || (mcr.el == HDT_EL1 && group1_register_trap);

    // effective controls: overrides never touch the stored bits
    assign route_eff = debug_exception_route_q || general_trap_enable;
    assign dbg_eff   = debug_access_trap_q || route_eff;
    assign rom_eff   = rom_address_trap || route_eff;
    assign os_eff    = os_related_trap || route_eff;

    hdt_trap_decode u_decode (
        .acc        (acc),
        .debug_halt (debug_halt),
        .rom_eff    (rom_eff),
        .os_eff     (os_eff),
        .dbg_eff    (dbg_eff),
        .route_eff  (route_eff),
        .mon_trap   (monitor_access_trap_q),
        .mcr_trap   (monitor_control_trap_q),
        .trap       (acc_trap_c)
    );

    hdt_counter_split #(
        .CNT_MAX (CNT_MAX)
    ) u_split (
        .split       (counter_split_q),
        .impl_count  (IMPL_COUNT),
        .global_en   (global_counter_enable),
        .hyp_cnt_en  (hyp_counter_enable_q),
        .hyp_disable (hyp_counting_disable),
        .in_hyp      (in_hyp),
        .lower_owned (lower_owned_c),
        .counter_run (counter_run_c)
    );

    // direct read view of stored fields
    always_comb
    begin
        reg_view = '0;
        reg_view[HDT_BIT_DBG_TRAP]  = debug_access_trap_q;
        reg_view[HDT_BIT_DBG_ROUTE] = debug_exception_route_q;
        if (PMU_PRESENT)
        begin
            reg_view[HDT_BIT_HYP_CNT_EN]           = hyp_counter_enable_q;
            reg_view[HDT_BIT_MON_TRAP]             = monitor_access_trap_q;
            reg_view[HDT_BIT_MCR_TRAP]             = monitor_control_trap_q;
            reg_view[HDT_SPLIT_MSB:0]              = counter_split_q;
        end
    end

    assign hyp_debug_trap_control = reg_view;

    // trap and routing bits
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            debug_access_trap_q     <= HDT_RST_TRAP;
            debug_exception_route_q <= HDT_RST_TRAP;
        end
        else if (hit && mcr.write && !take_trap)
        begin
            debug_access_trap_q     <= mcr.wdata[HDT_BIT_DBG_TRAP];
            debug_exception_route_q <= mcr.wdata[HDT_BIT_DBG_ROUTE];
        end
    end

    // performance monitor fields
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hyp_counter_enable_q   <= HDT_RST_CNT_EN;
            monitor_access_trap_q  <= HDT_RST_TRAP;
            monitor_control_trap_q <= HDT_RST_TRAP;
            counter_split_q        <= PMU_PRESENT ? IMPL_COUNT : '0;
        end
        else if (PMU_PRESENT && hit && mcr.write && !take_trap)
        begin
            hyp_counter_enable_q   <= mcr.wdata[HDT_BIT_HYP_CNT_EN];
            monitor_access_trap_q  <= mcr.wdata[HDT_BIT_MON_TRAP];
            monitor_control_trap_q <= mcr.wdata[HDT_BIT_MCR_TRAP];
            counter_split_q        <= mcr.wdata[HDT_SPLIT_MSB:0];
        end
    end

    // move request answer: one-cycle done or trap pulse
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q   <= HDT_ST_IDLE;
            mcr_rdata <= '0;
        end
        else
        begin
            case (state_q)
                HDT_ST_IDLE:
                begin
                    if (hit && take_trap)
                        state_q <= HDT_ST_TRAP;
                    else if (hit)
                    begin
                        state_q <= HDT_ST_DONE;
                        if (!mcr.write)
                            mcr_rdata <= reg_view;
                    end
                end
                HDT_ST_DONE: state_q <= HDT_ST_IDLE;
                HDT_ST_TRAP: state_q <= HDT_ST_IDLE;
                default:     state_q <= HDT_ST_IDLE;
            endcase
        end
    end

    assign mcr_done     = (state_q == HDT_ST_DONE);
    assign mcr_trap_exc = (state_q == HDT_ST_TRAP);

    // counter map registered so the outputs come from flops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lower_owned <= '0;
            counter_run <= '0;
        end
        else
        begin
            lower_owned <= lower_owned_c;
            counter_run <= counter_run_c;
        end
    end

    // access trap and exception routing are registered for timing
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_trap       <= 1'b0;
            dbg_exc_to_hyp <= 1'b0;
        end
        else
        begin
            acc_trap       <= acc_trap_c;
            dbg_exc_to_hyp <= dbg_exc_req && (dbg_exc_el != HDT_EL2) && route_eff;
        end
    end

    property p_route_exc;
        @(posedge core_clk) disable iff (!nrst)
        (dbg_exc_req && dbg_exc_el == HDT_EL0 && general_trap_enable) |=> dbg_exc_to_hyp;
    endproperty
    a_route_exc: assert property (p_route_exc) else $error("debug exception not routed");

    property p_no_xfer_trap_halt;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && acc.rclass == HDT_R_DBG_XFER && debug_halt) |=> !acc_trap;
    endproperty
    a_no_xfer_trap_halt: assert property (p_no_xfer_trap_halt) else $error("xfer trapped");

    property p_tge_forces_dbg;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && acc.el != HDT_EL2 && acc.rclass == HDT_R_DEBUG && general_trap_enable)
            |=> acc_trap;
    endproperty
    a_tge_forces_dbg: assert property (p_tge_forces_dbg) else $error("no forced trap");

    property p_ext_no_pmu_trap;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && acc.external && (acc.rclass == HDT_R_PMU || acc.rclass == HDT_R_PMU_CTRL))
            |=> !acc_trap;
    endproperty
    a_ext_no_pmu_trap: assert property (p_ext_no_pmu_trap) else $error("ext pmu trapped");

    property p_pmu_trap;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && !acc.external && acc.el == HDT_EL0 && acc.rclass == HDT_R_PMU
            && monitor_access_trap_q) |=> acc_trap;
    endproperty
    a_pmu_trap: assert property (p_pmu_trap) else $error("pmu access not trapped");

    property p_trap_no_write;
        @(posedge core_clk) disable iff (!nrst)
        (hit && take_trap) |=> ($stable(hyp_debug_trap_control) && mcr_trap_exc && !mcr_done);
    endproperty
    a_trap_no_write: assert property (p_trap_no_write) else $error("trapped move acted");

    property p_write_lands;
        @(posedge core_clk) disable iff (!nrst)
        (hit && mcr.write && !take_trap)
            |=> (debug_access_trap_q == $past(mcr.wdata[HDT_BIT_DBG_TRAP]) && mcr_done);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write not stored");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!nrst)
        hyp_debug_trap_control[HDT_XLEN-1:HDT_BIT_DBG_TRAP+1] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_rom_trap;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && acc.el != HDT_EL2 && acc.rclass == HDT_R_DBG_ROM && rom_address_trap)
            |=> acc_trap;
    endproperty
    a_rom_trap: assert property (p_rom_trap) else $error("rom access not trapped");

    property p_os_trap;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && acc.el == HDT_EL1 && acc.rclass == HDT_R_DBG_PWR && os_related_trap)
            |=> acc_trap;
    endproperty
    a_os_trap: assert property (p_os_trap) else $error("powerdown access not trapped");

    property p_mcr_ctrl_trap;
        @(posedge core_clk) disable iff (!nrst)
        (acc.valid && !acc.external && acc.el != HDT_EL2 && acc.rclass == HDT_R_PMU_CTRL
            && monitor_control_trap_q) |=> acc_trap;
    endproperty
    a_mcr_ctrl_trap: assert property (p_mcr_ctrl_trap) else $error("control not trapped");

    property p_read_answer;
        @(posedge core_clk) disable iff (!nrst)
        (hit && !mcr.write && !take_trap)
            |=> (mcr_done && mcr_rdata == $past(hyp_debug_trap_control));
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read data wrong");
endmodule

// [testbench/hyp_debug_trap_control_test.sv]
// hyp_debug_trap_control_test: self-checking bench for the hdt_ctrl register block
// assumes hdt_pkg is compiled first; the bench drives every input of the block itself
`timescale 1ns/1ps

`define CHK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end

module hyp_debug_trap_control_test
    import hdt_pkg::*;
;
    localparam logic [HDT_SPLIT_W-1:0] IMPL = 5'h06;

    logic                   core_clk;
    logic                   nrst;
    hdt_mcr_t               mcr;
    hdt_acc_t               acc;
    logic                   general_trap_enable;
    logic                   group1_register_trap;
    logic                   debug_halt;
    logic                   dbg_exc_req;
    hdt_el_t                dbg_exc_el;
    logic                   global_counter_enable;
    logic                   hyp_counting_disable;
    logic                   rom_address_trap;
    logic                   os_related_trap;
    logic                   in_hyp;
    logic                   mcr_done;
    logic                   mcr_trap_exc;
    logic [HDT_XLEN-1:0]    mcr_rdata;
    logic                   acc_trap;
    logic                   dbg_exc_to_hyp;
    logic [30:0]            lower_owned;
    logic [30:0]            counter_run;
    logic [HDT_XLEN-1:0]    view;
    logic [HDT_XLEN-1:0]    last_rd;
    int                     err_total;
    int                     n_tests;
    int                     cyc;

    hdt_ctrl #(.PMU_PRESENT(1'b1), .CNT_MAX(31), .IMPL_COUNT(IMPL)) dut_u (
        .core_clk               (core_clk),
        .nrst                   (nrst),
        .mcr                    (mcr),
        .acc                    (acc),
        .general_trap_enable    (general_trap_enable),
        .group1_register_trap   (group1_register_trap),
        .debug_halt             (debug_halt),
        .dbg_exc_req            (dbg_exc_req),
        .dbg_exc_el             (dbg_exc_el),
        .global_counter_enable  (global_counter_enable),
        .hyp_counting_disable   (hyp_counting_disable),
        .rom_address_trap       (rom_address_trap),
        .os_related_trap        (os_related_trap),
        .in_hyp                 (in_hyp),
        .mcr_done               (mcr_done),
        .mcr_trap_exc           (mcr_trap_exc),
        .mcr_rdata              (mcr_rdata),
        .acc_trap               (acc_trap),
        .dbg_exc_to_hyp         (dbg_exc_to_hyp),
        .lower_owned            (lower_owned),
        .counter_run            (counter_run),
        .hyp_debug_trap_control (view)
    );

    always #4 core_clk = ~core_clk;

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // a hung answer still ends the run through the common report
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run();
        end
    end

    // request held until the taking edge, then answers collected over three cycles
    task automatic move(input logic wr, input hdt_el_t el, input logic [2:0] op2,
                        input logic [31:0] wd, output logic dn, output logic tp);
        dn = 1'b0;
        tp = 1'b0;
        @(posedge core_clk);
        mcr <= '{1'b1, wr, HDT_OPC1, op2, HDT_CRN, HDT_CRM, HDT_CP_SYS, el, wd};
        @(posedge core_clk);
        mcr.valid <= 1'b0;
        repeat (3)
        begin
            #1;
            dn |= (mcr_done === 1'b1);
            tp |= (mcr_trap_exc === 1'b1);
            if (mcr_done === 1'b1)
                last_rd = mcr_rdata;
            @(posedge core_clk);
        end
    endtask

    task automatic wr_reg(input logic [9:0] rv);
        logic dn;
        logic tp;
        move(1'b1, HDT_EL2, HDT_OPC2, {22'h0, rv}, dn, tp);
    endtask

    task automatic t_regs;
        logic dn;
        logic tp;
        `CHK("reset view", {27'h0, IMPL}, view)
        move(1'b0, HDT_EL2, HDT_OPC2, 32'h0, dn, tp);
        `CHK("reset read", {27'h0, IMPL}, last_rd)
        move(1'b1, HDT_EL2, HDT_OPC2, 32'hffff_ffff, dn, tp);
        `CHK("write done", 1'b1, dn)
        move(1'b0, HDT_EL2, HDT_OPC2, 32'h0, dn, tp);
        `CHK("reserved read", 32'h0000_03ff, last_rd)
        wr_reg(10'h155);
        move(1'b1, HDT_EL2, 3'h0, 32'h0, dn, tp);
        `CHK("foreign answer", 2'b00, {dn, tp})
        move(1'b1, HDT_EL0, HDT_OPC2, 32'h0, dn, tp);
        `CHK("lowest trap", 2'b01, {dn, tp})
        @(posedge core_clk);
        group1_register_trap <= 1'b1;
        move(1'b1, HDT_EL1, HDT_OPC2, 32'h0, dn, tp);
        `CHK("group1 trap", 2'b01, {dn, tp})
        `CHK("trapped no write", 32'h0000_0155, view)
        @(posedge core_clk);
        group1_register_trap <= 1'b0;
        move(1'b1, HDT_EL1, HDT_OPC2, 32'h6, dn, tp);
        `CHK("first level write", 32'h0000_0006, view)
        $display("test registers done");
    endtask

    // ctl packs general trap, debug halt, rom trap and os trap in that order
    task automatic acc_case(input logic [9:0] rv, input logic [3:0] ctl, input hdt_el_t el,
                            input hdt_rclass_t rc, input logic ext, input logic exp);
        wr_reg(rv);
        @(posedge core_clk);
        {general_trap_enable, debug_halt, rom_address_trap, os_related_trap} <= ctl;
        acc <= '{1'b1, el, rc, ext};
        @(posedge core_clk);
        #1;
        `CHK("access trap", exp, acc_trap)
        `CHK("direct read", {22'h0, rv}, view)
    endtask

    task automatic t_access;
        acc_case(10'h206, 4'h0, HDT_EL1, HDT_R_DEBUG, 1'b0, 1'b1);
        acc_case(10'h006, 4'h0, HDT_EL0, HDT_R_DEBUG, 1'b0, 1'b0);
        acc_case(10'h006, 4'h8, HDT_EL0, HDT_R_DEBUG, 1'b0, 1'b1);
        acc_case(10'h106, 4'h0, HDT_EL1, HDT_R_DEBUG, 1'b0, 1'b1);
        acc_case(10'h206, 4'h4, HDT_EL1, HDT_R_DBG_XFER, 1'b0, 1'b0);
        acc_case(10'h206, 4'h0, HDT_EL1, HDT_R_DBG_XFER, 1'b0, 1'b1);
        acc_case(10'h206, 4'h0, HDT_EL2, HDT_R_DEBUG, 1'b0, 1'b0);
        acc_case(10'h206, 4'h0, HDT_EL1, HDT_R_DBG_ROM, 1'b0, 1'b0);
        acc_case(10'h046, 4'h0, HDT_EL0, HDT_R_PMU, 1'b0, 1'b1);
        acc_case(10'h046, 4'h0, HDT_EL0, HDT_R_PMU, 1'b1, 1'b0);
        acc_case(10'h006, 4'h0, HDT_EL1, HDT_R_PMU, 1'b0, 1'b0);
        acc_case(10'h026, 4'h0, HDT_EL1, HDT_R_PMU_CTRL, 1'b0, 1'b1);
        acc_case(10'h006, 4'h2, HDT_EL0, HDT_R_DBG_ROM, 1'b0, 1'b1);
        acc_case(10'h006, 4'h1, HDT_EL1, HDT_R_DBG_PWR, 1'b0, 1'b1);
        acc_case(10'h106, 4'h0, HDT_EL0, HDT_R_DBG_PWR, 1'b0, 1'b0);
        $display("test access traps done");
    endtask

    task automatic dbg_case(input logic [9:0] rv, input logic tg, input hdt_el_t el,
                            input logic exp);
        wr_reg(rv);
        @(posedge core_clk);
        general_trap_enable <= tg;
        dbg_exc_req <= 1'b1;
        dbg_exc_el <= el;
        @(posedge core_clk);
        dbg_exc_req <= 1'b0;
        #1;
        `CHK("debug route", exp, dbg_exc_to_hyp)
    endtask

    task automatic t_debug;
        dbg_case(10'h106, 1'b0, HDT_EL0, 1'b1);
        dbg_case(10'h106, 1'b0, HDT_EL1, 1'b1);
        dbg_case(10'h006, 1'b0, HDT_EL1, 1'b0);
        dbg_case(10'h006, 1'b1, HDT_EL0, 1'b1);
        dbg_case(10'h106, 1'b0, HDT_EL2, 1'b0);
        $display("test debug routing done");
    endtask

    // the six implemented counters are judged by value; counters 6 to 30 must read zero
    task automatic split_case(input logic [9:0] rv, input logic [2:0] ctl,
                              input logic [5:0] own, input logic [5:0] run);
        wr_reg(rv);
        @(posedge core_clk);
        {global_counter_enable, hyp_counting_disable, in_hyp} <= ctl;
        @(posedge core_clk);
        #1;
        `CHK("lower owned", own, lower_owned[5:0])
        `CHK("counter run", run, counter_run[5:0])
        `CHK("idle counters", 50'h0, {lower_owned[30:6], counter_run[30:6]})
    endtask

    task automatic t_split;
        split_case(10'h002, 3'b100, 6'h03, 6'h03);
        split_case(10'h082, 3'b100, 6'h03, 6'h3f);
        split_case(10'h082, 3'b000, 6'h03, 6'h3c);
        split_case(10'h082, 3'b111, 6'h03, 6'h3c);
        split_case(10'h082, 3'b110, 6'h03, 6'h3f);
        split_case(10'h080, 3'b100, 6'h00, 6'h3f);
        split_case(10'h087, 3'b100, 6'h00, 6'h3f);
        split_case(10'h006, 3'b100, 6'h3f, 6'h3f);
        $display("test counter split done");
    endtask

    // a second reset mid-run must bring back the reset values over written ones
    task automatic t_reset;
        wr_reg(10'h3e3);
        @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("mid reset view", {27'h0, IMPL}, view)
        @(posedge core_clk);
        nrst <= 1'b1;
        $display("test reset done");
    endtask

    initial
    begin
        core_clk = 1'b0;
        nrst = 1'b0;
        mcr = '0;
        acc = '0;
        {general_trap_enable, group1_register_trap, debug_halt, dbg_exc_req} = 4'h0;
        dbg_exc_el = HDT_EL0;
        {global_counter_enable, hyp_counting_disable, in_hyp} = 3'h0;
        {rom_address_trap, os_related_trap} = 2'h0;
        last_rd = '0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        t_regs();
        t_reset();
        t_access();
        t_debug();
        t_split();
        complete_run();
    end
endmodule
